// ==== rtl/dual_clock_fifo.sv ====
// Purpose: First-in first-out word buffer between two unrelated clocks
// Assumes: Depth is a power of two of at least four words
// Notes: RST_B_IN is the asynchronous clear for both domains
// Overview of operation
// - Read strobe, read flags and read count change only on read clock edges.
// - Write strobe, write flags and write count change only on write clock edges.
// - A write strobe stores the input word at the next write clock edge.
// - With overflow checking on, writes are ignored while full is set.
// - Normal mode: a read strobe puts the oldest word out next edge.
// - Prefetch mode: oldest word already shown; a strobe advances to the next.
// - With underflow checking on, reads are ignored while empty is set.
// - Clear empties the buffer, resets flags, keeps or zeroes read data.
// - Read empty is set when the next read pointer meets the synchronised write pointer.
// - Read empty falls after a first write only after synchroniser latency.
// - Write full asserts when full; write count then equals depth with extra bit, else zero, as both use the same read pointer.
// - Write-side empty and read-side full are resynchronised copies of the flags.
// - Each domain outputs its own word count, fill count width wide.
// - Extra top bit option widens both counts by one bit.
// - Depth is a power of two; data ports are word width wide.
// - Full flags may assert early, with up to three words unwritten.
// - Read mode select on gives prefetch, off gives normal, off default.
// - Full buffer count wraps to zero, or shows depth with extra bit.
// - Write to read synchroniser length is configurable, default three stages.
// - A write clears read empty one write cycle plus three read edges later.
// - Overflow and underflow checking selectable, both on by default.
`timescale 1ns/10ps
module dual_clock_fifo
    import fifo_pkg::*;
#(
    parameter int word_width = WORD_WIDTH_DEF,
    parameter int buffer_depth = BUFFER_DEPTH_DEF,
    parameter int fill_count_width = FILL_COUNT_WIDTH_DEF,
    parameter bit read_mode_select = OPT_OFF,
    parameter bit overflow_check = OPT_ON,
    parameter bit underflow_check = OPT_ON,
    parameter bit extra_msb = OPT_OFF,
    parameter bit clear_read_data = OPT_OFF,
    parameter int read_sync_stages = SYNC_STAGES_DEF,
    parameter int write_sync_stages = SYNC_STAGES_DEF,
    localparam int CNT_W = fill_count_width + int'(extra_msb)
) (
    // Clocks and asynchronous clear
    input wire logic WR_CLK_IN,
    input wire logic RD_CLK_IN,
    input wire logic RST_B_IN,
    // Write side
    input wire logic WR_REQ_IN,
    input wire logic [word_width-1:0] WR_DATA_IN,
    output logic WR_FULL_OUT,
    output logic WR_EMPTY_OUT,
    output logic [CNT_W-1:0] WR_USED_OUT,
    // Read side
    input wire logic RD_REQ_IN,
    output logic [word_width-1:0] RD_DATA_OUT,
    output logic RD_EMPTY_OUT,
    output logic RD_FULL_OUT,
    output logic [CNT_W-1:0] RD_USED_OUT
);
    localparam int ADDR_W = $clog2(buffer_depth);
    localparam int PTR_W = ADDR_W + 1;

    // Gray encode; used for both pointers
    function automatic logic [PTR_W-1:0] bin2gray(input logic [PTR_W-1:0] b);
        return b ^ (b >> 1);
    endfunction

    // Gray decode; used on both synchronised pointers
    function automatic logic [PTR_W-1:0] gray2bin(input logic [PTR_W-1:0] g);
        logic [PTR_W-1:0] b;
        b = '0;
        for (int i = PTR_W - 1; i >= 0; i--) begin
            b[i] = g[i] ^ ((i == PTR_W - 1) ? 1'b0 : b[(i == PTR_W - 1) ? 0 : i + 1]);
        end
        return b;
    endfunction

    fifo_mem_if #(.AW(ADDR_W), .DW(word_width)) mem ();

    // Write domain state
    logic [PTR_W-1:0] wr_bin_r;
    logic [PTR_W-1:0] wr_gray_r;
    logic wr_full_r;
    logic wr_empty_r;
    logic [CNT_W-1:0] wr_used_r;
    // Read domain state
    logic [PTR_W-1:0] rd_bin_r;
    logic [PTR_W-1:0] rd_gray_r;
    logic rd_empty_r;
    logic rd_full_r;
    logic [CNT_W-1:0] rd_used_r;
    logic [word_width-1:0] rd_data_r;
    // Crossings
    logic [PTR_W-1:0] rd_gray_ws;
    logic [PTR_W-1:0] wr_gray_rs;
    logic rd_empty_ws;
    logic wr_full_rs;
    // Next values
    logic wr_accept;
    logic rd_accept;
    logic [PTR_W-1:0] wr_bin_nxt;
    logic [PTR_W-1:0] wr_gray_nxt;
    logic [PTR_W-1:0] rd_bin_ws;
    logic wr_full_nxt;
    logic [CNT_W-1:0] wr_used_nxt;
    logic [PTR_W-1:0] rd_bin_nxt;
    logic [PTR_W-1:0] rd_gray_nxt;
    logic [PTR_W-1:0] wr_bin_rs;
    logic rd_empty_nxt;
    logic [CNT_W-1:0] rd_used_nxt;

    // Storage array, written in the write domain only
    fifo_store #(.DEPTH(buffer_depth)) u_store (
        .wr_clk_in(WR_CLK_IN),
        .mem(mem.store)
    );

    // Read pointer into the write domain; the full register ends the chain
    fifo_sync #(.W(PTR_W), .STAGES(write_sync_stages - 1)) u_rd_ptr_sync (
        .clk_in(WR_CLK_IN),
        .rst_b_in(RST_B_IN),
        .d_in(rd_gray_r),
        .q_out(rd_gray_ws)
    );

    // Write pointer into the read domain; the empty register ends the chain
    fifo_sync #(.W(PTR_W), .STAGES(read_sync_stages - 1)) u_wr_ptr_sync (
        .clk_in(RD_CLK_IN),
        .rst_b_in(RST_B_IN),
        .d_in(wr_gray_r),
        .q_out(wr_gray_rs)
    );

    // Read empty copied into the write domain
    fifo_sync #(.W(1), .STAGES(write_sync_stages), .RST_VAL(EMPTY_RST)) u_empty_sync (
        .clk_in(WR_CLK_IN),
        .rst_b_in(RST_B_IN),
        .d_in(rd_empty_r),
        .q_out(rd_empty_ws)
    );

    // Write full copied into the read domain
    fifo_sync #(.W(1), .STAGES(read_sync_stages), .RST_VAL(FULL_RST)) u_full_sync (
        .clk_in(RD_CLK_IN),
        .rst_b_in(RST_B_IN),
        .d_in(wr_full_r),
        .q_out(wr_full_rs)
    );

    // Write acceptance and next pointer
    always_comb begin
        wr_accept = WR_REQ_IN && !(overflow_check && wr_full_r);
        wr_bin_nxt = wr_bin_r + PTR_W'(wr_accept);
        wr_gray_nxt = bin2gray(wr_bin_nxt);
        rd_bin_ws = gray2bin(rd_gray_ws);
        // Full when the gray pointers differ only in their top two bits
        wr_full_nxt = (wr_gray_nxt == {~rd_gray_ws[PTR_W-1 -: 2], rd_gray_ws[PTR_W-3:0]});
        // Stale read pointer can only overstate the fill, so full errs early
        wr_used_nxt = CNT_W'(wr_bin_nxt - rd_bin_ws);
    end

    // Storage write port
    assign mem.we = wr_accept;
    assign mem.waddr = wr_bin_r[ADDR_W-1:0];
    assign mem.wdata = WR_DATA_IN;

    // Write pointers
    always_ff @(posedge WR_CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            wr_bin_r <= '0;
            wr_gray_r <= '0;
        end else begin
            wr_bin_r <= wr_bin_nxt;
            wr_gray_r <= wr_gray_nxt;
        end
    end

    // Write side flags and count
    always_ff @(posedge WR_CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            wr_full_r <= FULL_RST;
            wr_empty_r <= EMPTY_RST;
            wr_used_r <= '0;
        end else begin
            wr_full_r <= wr_full_nxt;
            wr_empty_r <= rd_empty_ws;
            wr_used_r <= wr_used_nxt;
        end
    end

    // Read acceptance and next pointer
    always_comb begin
        rd_accept = RD_REQ_IN && !(underflow_check && rd_empty_r);
        rd_bin_nxt = rd_bin_r + PTR_W'(rd_accept);
        rd_gray_nxt = bin2gray(rd_bin_nxt);
        wr_bin_rs = gray2bin(wr_gray_rs);
        rd_empty_nxt = (rd_gray_nxt == wr_gray_rs);
        rd_used_nxt = CNT_W'(wr_bin_rs - rd_bin_nxt);
    end

    // Prefetch looks one word ahead so the head is already on the output
    assign mem.raddr = read_mode_select ? rd_bin_nxt[ADDR_W-1:0] : rd_bin_r[ADDR_W-1:0];

    // Read pointers
    always_ff @(posedge RD_CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            rd_bin_r <= '0;
            rd_gray_r <= '0;
        end else begin
            rd_bin_r <= rd_bin_nxt;
            rd_gray_r <= rd_gray_nxt;
        end
    end

    // Read side flags and count
    always_ff @(posedge RD_CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            rd_empty_r <= EMPTY_RST;
            rd_full_r <= FULL_RST;
            rd_used_r <= '0;
        end else begin
            rd_empty_r <= rd_empty_nxt;
            rd_full_r <= wr_full_rs;
            rd_used_r <= rd_used_nxt;
        end
    end

    // Read data register; clear either zeroes it or leaves it alone
    generate
        if (clear_read_data) begin : g_q_clear
            always_ff @(posedge RD_CLK_IN or negedge RST_B_IN) begin
                if (!RST_B_IN) begin
                    rd_data_r <= '0;
                end else if (read_mode_select || rd_accept) begin
                    rd_data_r <= mem.rdata;
                end
            end
        end else begin : g_q_keep
            // No reset here so a clear does not disturb the last word read
            always_ff @(posedge RD_CLK_IN) begin
                if (read_mode_select || rd_accept) begin
                    rd_data_r <= mem.rdata;
                end
            end
        end
    endgenerate

    // Outputs straight from flops
    assign WR_FULL_OUT = wr_full_r;
    assign WR_EMPTY_OUT = wr_empty_r;
    assign WR_USED_OUT = wr_used_r;
    assign RD_DATA_OUT = rd_data_r;
    assign RD_EMPTY_OUT = rd_empty_r;
    assign RD_FULL_OUT = rd_full_r;
    assign RD_USED_OUT = rd_used_r;

    // Checks on the write domain
    property p_wr_ignored_when_full;
        @(posedge WR_CLK_IN) disable iff (!RST_B_IN)
        (overflow_check && wr_full_r) |=> (wr_bin_r == $past(wr_bin_r));
    endproperty
    a_wr_ignored_when_full: assert property (p_wr_ignored_when_full)
        else $error("write accepted while full");

    property p_wr_advances;
        @(posedge WR_CLK_IN) disable iff (!RST_B_IN)
        (WR_REQ_IN && !wr_full_r) |=> (wr_bin_r == $past(wr_bin_r) + PTR_W'(PTR_STEP));
    endproperty
    a_wr_advances: assert property (p_wr_advances)
        else $error("write strobe did not advance write pointer");

    property p_wr_gray_step;
        @(posedge WR_CLK_IN) disable iff (!RST_B_IN)
        ##1 ($countones(wr_gray_r ^ $past(wr_gray_r)) <= 1);
    endproperty
    a_wr_gray_step: assert property (p_wr_gray_step)
        else $error("write gray pointer changed more than one bit");

    property p_full_count;
        @(posedge WR_CLK_IN) disable iff (!RST_B_IN)
        wr_full_r |-> (wr_used_r == CNT_W'(buffer_depth));
    endproperty
    a_full_count: assert property (p_full_count)
        else $error("count wrong while full");

    property p_full_margin;
        @(posedge WR_CLK_IN) disable iff (!RST_B_IN)
        wr_full_r |-> ((PTR_W'(wr_bin_r - rd_bin_ws)) >= PTR_W'(buffer_depth - FULL_MARGIN));
    endproperty
    a_full_margin: assert property (p_full_margin)
        else $error("full flag set too early");

    // A refused write must keep the pointer gap within one buffer of words
    property p_count_bound;
        @(posedge WR_CLK_IN) disable iff (!RST_B_IN)
        overflow_check |-> ((PTR_W'(wr_bin_r - rd_bin_ws)) <= PTR_W'(buffer_depth));
    endproperty
    a_count_bound: assert property (p_count_bound)
        else $error("write pointer ran past a full buffer");

    property p_depth_pow2;
        @(posedge WR_CLK_IN) disable iff (!RST_B_IN)
        ((buffer_depth & (buffer_depth - 1)) == 0) && (read_sync_stages >= SYNC_STAGES_MIN);
    endproperty
    a_depth_pow2: assert property (p_depth_pow2)
        else $error("depth not a power of two or synchroniser too short");

    // Checks on the read domain
    property p_rd_ignored_when_empty;
        @(posedge RD_CLK_IN) disable iff (!RST_B_IN)
        (underflow_check && rd_empty_r) |=> $stable(rd_bin_r);
    endproperty
    a_rd_ignored_when_empty: assert property (p_rd_ignored_when_empty)
        else $error("read accepted while empty");

    property p_empty_count;
        @(posedge RD_CLK_IN) disable iff (!RST_B_IN)
        rd_empty_r |-> (rd_used_r == '0);
    endproperty
    a_empty_count: assert property (p_empty_count)
        else $error("empty with nonzero count");

    property p_empty_release;
        @(posedge RD_CLK_IN) disable iff (!RST_B_IN)
        (wr_gray_rs != rd_gray_nxt) |=> !rd_empty_r;
    endproperty
    a_empty_release: assert property (p_empty_release)
        else $error("empty not released after pointer arrived");

    property p_normal_read_data;
        @(posedge RD_CLK_IN) disable iff (!RST_B_IN)
        (!read_mode_select && rd_accept) |=> (rd_data_r == $past(mem.rdata));
    endproperty
    a_normal_read_data: assert property (p_normal_read_data)
        else $error("normal read data wrong");

    // Head word already shown must hold until a strobe acknowledges it
    property p_prefetch_head;
        @(posedge RD_CLK_IN) disable iff (!RST_B_IN)
        (read_mode_select && !rd_empty_r && !RD_REQ_IN) |=> $stable(rd_data_r);
    endproperty
    a_prefetch_head: assert property (p_prefetch_head)
        else $error("prefetch head word moved without a read strobe");
endmodule // dual_clock_fifo

// ==== rtl/fifo_pkg.sv ====
// Purpose: Shared constants for the dual clock word buffer
// Assumes: Included before every other design file
// Notes: Option values, reset values and default sizes live here
package fifo_pkg;
    // Option switch values
    localparam bit OPT_ON = 1'b1;
    localparam bit OPT_OFF = 1'b0;
    // Default geometry; depth must stay a power of two
    localparam int WORD_WIDTH_DEF = 8;
    localparam int BUFFER_DEPTH_DEF = 16;
    localparam int FILL_COUNT_WIDTH_DEF = 4;
    // Synchroniser length, counting the flag register that ends the chain
    localparam int SYNC_STAGES_DEF = 3;
    localparam int SYNC_STAGES_MIN = 2;
    // Flag reset values: buffer starts empty and not full
    localparam bit EMPTY_RST = 1'b1;
    localparam bit FULL_RST = 1'b0;
    // Margin by which the full flag may run ahead of the true fill
    localparam int FULL_MARGIN = 3;
    // Pointer step per accepted access
    localparam int PTR_STEP = 1;
endpackage

// ==== rtl/fifo_mem_if.sv ====
// Purpose: Carries the storage port between control logic and the array
// Assumes: Write side fields are driven in the write clock domain
// Notes: Read data is combinational from the read address
`timescale 1ns/10ps
interface fifo_mem_if #(
    parameter int AW = 4,
    parameter int DW = 8
);
    logic we;
    logic [AW-1:0] waddr;
    logic [DW-1:0] wdata;
    logic [AW-1:0] raddr;
    logic [DW-1:0] rdata;
    // Control logic side
    modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
    // Storage side
    modport store (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

// ==== rtl/fifo_store.sv ====
// Purpose: Word storage written on the write clock, read asynchronously
// Assumes: Reader only addresses words the pointers mark as valid
// Notes: No reset, contents are undefined until written
`timescale 1ns/10ps
module fifo_store #(
    parameter int DEPTH = 16
) (
    // Write clock
    input wire logic wr_clk_in,
    // Storage port
    fifo_mem_if.store mem
);
    logic [$bits(mem.wdata)-1:0] words [DEPTH];

    // Capture on the write clock only
    always_ff @(posedge wr_clk_in) begin
        if (mem.we) begin
            words[mem.waddr] <= mem.wdata;
        end
    end

    // Read path is registered by the consumer in its own domain
    assign mem.rdata = words[mem.raddr];
endmodule // fifo_store

// ==== rtl/fifo_sync.sv ====
// Purpose: Multi stage synchroniser for levels and gray coded words
// Assumes: Input changes at most one bit per source clock
// Notes: Only the last stage may be read by other logic
`timescale 1ns/10ps
module fifo_sync #(
    parameter int W = 1,
    parameter int STAGES = 2,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // Destination clock and reset
    input wire logic clk_in,
    input wire logic rst_b_in,
    // Data
    input wire logic [W-1:0] d_in,
    output logic [W-1:0] q_out
);
    logic [W-1:0] stage_r [STAGES];

    // Chain of flops, each reads only its predecessor
    genvar gi;
    generate
        for (gi = 0; gi < STAGES; gi++) begin : g_stage
            always_ff @(posedge clk_in or negedge rst_b_in) begin
                if (!rst_b_in) begin
                    stage_r[gi] <= RST_VAL;
                end else begin
                    stage_r[gi] <= (gi == 0) ? d_in : stage_r[(gi == 0) ? 0 : gi-1];
                end
            end
        end
    endgenerate

    assign q_out = stage_r[STAGES-1];
endmodule // fifo_sync

// ==== dv/fifo_user_model.sv ====
// Purpose: Write-side and read-side user logic facing the word buffer
// Assumes: Strobes change only on falling edges of their own clocks
// Notes: Writer runs fast or slow; a released data bus shows the inverted word
`timescale 1ns/10ps
module fifo_user_model
    import fifo_pkg::*;
#(
    parameter int W = WORD_WIDTH_DEF
) (
    // Clocks
    input wire logic wr_clk_in,
    input wire logic rd_clk_in,
    // Write side
    output logic wr_req_out,
    output logic [W-1:0] wr_data_out,
    // Read side, one strobe for the normal mode instances and one for the prefetch instance
    output logic rd_req_out,
    output logic rd_req_pf_out
);
    // Idle strobes from time zero, so no clear release ever sees one high
    initial begin
        wr_req_out = 1'b0;
        wr_data_out = '0;
        rd_req_out = 1'b0;
        rd_req_pf_out = 1'b0;
    end

    // Counting words from base; a slow writer idles one cycle after each word
    task automatic write_burst(input logic [W-1:0] base, input int n, input bit slow);
        for (int i = 0; i < n; i++) begin
            @(negedge wr_clk_in);
            wr_req_out = 1'b1;
            wr_data_out = base + W'(i);
            if (slow) begin
                @(negedge wr_clk_in);
                wr_req_out = 1'b0;
                wr_data_out = ~wr_data_out;
            end
        end
        if (!slow) begin
            @(negedge wr_clk_in);
            wr_req_out = 1'b0;
            wr_data_out = ~wr_data_out; // No stale word left on a released bus
        end
    endtask

    // Strobes the chosen read sides for n consecutive read cycles
    task automatic read_burst(input bit norm, input bit pf, input int n);
        for (int i = 0; i < n; i++) begin
            @(negedge rd_clk_in);
            rd_req_out = norm;
            rd_req_pf_out = pf;
        end
        @(negedge rd_clk_in);
        rd_req_out = 1'b0;
        rd_req_pf_out = 1'b0;
    endtask
endmodule // fifo_user_model

// ==== dv/dual_clock_fifo_tb.sv ====
// Purpose: Self-checking bench for the dual clock word buffer
// Assumes: Three instances, normal mode, prefetch with extra count bit, and normal without overflow checking
// Notes: Queues predict every word; full is judged only while nothing is read
`timescale 1ns/10ps
module dual_clock_fifo_tb;
    import fifo_pkg::*;
    localparam int W = WORD_WIDTH_DEF;
    localparam int DEPTH = BUFFER_DEPTH_DEF; // Three above a real need of 13
    localparam int FCW = $clog2(DEPTH);
    // Clocks, clear and strobes
    logic wr_clk = 1'b0;
    logic rd_clk = 1'b0;
    logic rst_b = 1'b0;
    logic wr_req, rd_req, rd_req_pf;
    logic [W-1:0] wr_data;
    // Normal mode instance outputs
    logic wr_full, wr_empty, rd_empty, rd_full;
    logic [FCW-1:0] wr_used, rd_used;
    logic [W-1:0] rd_data;
    // Prefetch instance outputs
    logic wr_full_pf, wr_empty_pf, rd_empty_pf, rd_full_pf;
    logic [FCW:0] wr_used_pf, rd_used_pf;
    logic [W-1:0] rd_data_pf;
    // Instance without overflow checking
    logic wr_full_nc, rd_empty_nc;
    logic [FCW-1:0] wr_used_nc, rd_used_nc;
    // Predicted contents and counters
    logic [W-1:0] wq[$];
    logic [W-1:0] pq[$];
    int n_fail = 0;
    int checks = 0;

    // Write clock 100 ns; read clock 130 ns, so edges of the two coincide once every 650 ns
    always #50 wr_clk = ~wr_clk;
    always #65 rd_clk = ~rd_clk;

    fifo_user_model #(.W(W)) u_fifo_user_model (
        .wr_clk_in(wr_clk), .rd_clk_in(rd_clk), .wr_req_out(wr_req),
        .wr_data_out(wr_data), .rd_req_out(rd_req), .rd_req_pf_out(rd_req_pf)
    );
    dual_clock_fifo #(.fill_count_width(FCW)) u_dual_clock_fifo (
        .WR_CLK_IN(wr_clk), .RD_CLK_IN(rd_clk), .RST_B_IN(rst_b),
        .WR_REQ_IN(wr_req), .WR_DATA_IN(wr_data), .WR_FULL_OUT(wr_full),
        .WR_EMPTY_OUT(wr_empty), .WR_USED_OUT(wr_used), .RD_REQ_IN(rd_req),
        .RD_DATA_OUT(rd_data), .RD_EMPTY_OUT(rd_empty), .RD_FULL_OUT(rd_full),
        .RD_USED_OUT(rd_used)
    );
    dual_clock_fifo #(.fill_count_width(FCW), .read_mode_select(OPT_ON), .extra_msb(OPT_ON),
        .clear_read_data(OPT_ON)) u_dual_clock_fifo_pf (
        .WR_CLK_IN(wr_clk), .RD_CLK_IN(rd_clk), .RST_B_IN(rst_b),
        .WR_REQ_IN(wr_req), .WR_DATA_IN(wr_data), .WR_FULL_OUT(wr_full_pf),
        .WR_EMPTY_OUT(wr_empty_pf), .WR_USED_OUT(wr_used_pf), .RD_REQ_IN(rd_req_pf),
        .RD_DATA_OUT(rd_data_pf), .RD_EMPTY_OUT(rd_empty_pf), .RD_FULL_OUT(rd_full_pf),
        .RD_USED_OUT(rd_used_pf)
    );
    dual_clock_fifo #(.fill_count_width(FCW), .overflow_check(OPT_OFF)) u_dual_clock_fifo_nc (
        .WR_CLK_IN(wr_clk), .RD_CLK_IN(rd_clk), .RST_B_IN(rst_b),
        .WR_REQ_IN(wr_req), .WR_DATA_IN(wr_data), .WR_FULL_OUT(wr_full_nc),
        .WR_EMPTY_OUT(), .WR_USED_OUT(wr_used_nc), .RD_REQ_IN(rd_req),
        .RD_DATA_OUT(), .RD_EMPTY_OUT(rd_empty_nc), .RD_FULL_OUT(),
        .RD_USED_OUT(rd_used_nc)
    );

    // Compares one value and reports a mismatch at once
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    // Prints counts and verdict, then ends the run
    task automatic conclude();
        $display("Counts: %0d checks, %0d mismatches", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Accepted writes; own fill count stands in for the full flag
    always @(posedge wr_clk) begin
        if (rst_b && wr_req && wq.size() < DEPTH) begin
            wq.push_back(wr_data);
            pq.push_back(wr_data);
        end
    end

    // Normal mode: oldest word appears just after an accepted strobe
    always @(posedge rd_clk) begin
        if (rst_b && rd_req && rd_empty === 1'b0) begin
            #1 check(rd_data, wq.pop_front());
        end
    end

    // Prefetch mode: head word stands on the output whenever not empty
    always @(posedge rd_clk) begin
        if (rst_b && rd_req_pf && rd_empty_pf === 1'b0) begin
            void'(pq.pop_front());
        end
        #1;
        if (rd_empty_pf === 1'b0) begin
            check(rd_data_pf, pq[0]);
        end
    end

    // Cuts a hang short, counted as a mismatch
    initial begin
        #2000000;
        check(32'h0, 32'h1);
        conclude();
    end

    initial begin
        repeat (5) @(negedge wr_clk);
        check({wr_full, wr_empty, rd_empty, rd_full}, 4'b0110);
        check({wr_full_pf, wr_empty_pf, rd_empty_pf, rd_full_pf}, 4'b0110);
        rst_b = 1'b1;
        check({wr_used, rd_used_pf}, '0);
        // Reads on an empty buffer are ignored
        u_fifo_user_model.read_burst(1'b1, 1'b1, 2);
        check({rd_empty, rd_empty_pf, rd_used}, {2'b11, FCW'(0)});
        $display("Test reset and underflow done");
        // One word: write count at once, read empty after three read edges
        fork
            u_fifo_user_model.write_burst(8'h5a, 1, 1'b0);
            begin
                // The burst raises its strobe at this falling edge; the next rise takes it
                @(negedge wr_clk);
                @(posedge wr_clk);
                #1 check(wr_used, FCW'(1));
                repeat (2) @(posedge rd_clk);
                #1 check(rd_empty, 1'b1);
                @(posedge rd_clk);
                #1 check({rd_empty, rd_used}, {1'b0, FCW'(1)});
            end
        join
        repeat (6) @(negedge wr_clk);
        check({wr_empty, wr_empty_pf}, 2'b00);
        u_fifo_user_model.read_burst(1'b1, 1'b1, 1);
        check({rd_empty, rd_used}, {1'b1, FCW'(0)});
        $display("Test latency done");
        // Slow writer while the reader strobes throughout, empty reads among them
        fork
            u_fifo_user_model.write_burst(8'h10, 6, 1'b1);
            u_fifo_user_model.read_burst(1'b1, 1'b1, 14);
        join
        u_fifo_user_model.read_burst(1'b1, 1'b1, 4);
        check(wq.size(), 32'h0);
        $display("Test streaming done");
        // Twenty strobes into sixteen words: the two checked instances drop the last four
        u_fifo_user_model.write_burst(8'h40, DEPTH + 4, 1'b0);
        check({wr_full, wr_used}, {1'b1, FCW'(0)});
        check({wr_full_pf, wr_used_pf}, {1'b1, (FCW + 1)'(DEPTH)});
        // Unchecked instance takes all twenty, so its count wraps past the depth to four
        check({wr_full_nc, wr_used_nc}, {1'b0, FCW'(DEPTH + 4)});
        repeat (6) @(negedge rd_clk);
        check({rd_full, rd_full_pf, rd_used_pf}, {2'b11, (FCW + 1)'(DEPTH)});
        u_fifo_user_model.read_burst(1'b1, 1'b1, DEPTH);
        repeat (6) @(negedge wr_clk);
        check({wr_full, wr_empty, rd_empty, rd_full}, 4'b0110);
        check({rd_empty_nc, rd_used_nc}, {1'b0, FCW'(4)});
        $display("Test overflow done");
        // Clear with words stored: normal output keeps, prefetch output zeroes
        u_fifo_user_model.write_burst(8'h80, 3, 1'b0);
        repeat (6) @(negedge rd_clk);
        @(negedge wr_clk);
        rst_b = 1'b0;
        #1 check({wr_full, wr_empty, rd_empty, rd_full, wr_used, rd_used}, {4'b0110, 8'h00});
        check({rd_data, rd_data_pf}, {8'h4f, 8'h00});
        wq.delete();
        pq.delete();
        repeat (2) @(negedge wr_clk);
        rst_b = 1'b1; // Strobes are low at release
        u_fifo_user_model.write_burst(8'h77, 1, 1'b0);
        repeat (6) @(negedge rd_clk);
        u_fifo_user_model.read_burst(1'b1, 1'b1, 1);
        check(wq.size(), 32'h0);
        $display("Test clear done");
        conclude();
    end
endmodule // dual_clock_fifo_tb
